//--- ssdl_start_stop.sv
/*
 Start, stop and direction logic for a motor drive in modes 2, 3 and 4.
 Turns the control inputs, run enable and keypad buttons into run, direction
 and zero-frequency commands. Assumes pins are asynchronous and that the
 mode and keypad stop enable settings are quasi-static from the same clock.
*/
`timescale 1ns/1ns
module ssdl_start_stop
	import ssdl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [2:0] startStopLogicSelect,
	input wire logic keypadStopEnable,
	input wire ssdl_in_t pinIn,
	output ssdl_cmd_t cmdOut
);
	typedef enum logic [3:0] {
		SSDL_IDLE = 4'h1,
		SSDL_FWD = 4'h2,
		SSDL_REV = 4'h4,
		SSDL_LOCK = 4'h8
	} ssdl_state_t;

	ssdl_state_t state_r;
	ssdl_state_t state_nxt;
	ssdl_in_t syncIn;
	ssdl_in_t riseIn;
	logic [2:0] mode_r;
	ssdl_cmd_t cmd_r;
	ssdl_cmd_t cmd_nxt;

	ssdl_sync #(
		.WIDTH($bits(ssdl_in_t))
	) uSync (
		.ref_clk(ref_clk),
		.reset(reset),
		.asyncIn(pinIn),
		.syncOut(syncIn)
	);

	ssdl_edge #(
		.WIDTH($bits(ssdl_in_t))
	) uEdge (
		.ref_clk(ref_clk),
		.reset(reset),
		.level(syncIn),
		.rise(riseIn),
		.fall()
	);

	// Named decodes of the selection and stop conditions
	wire isTwoDir = (startStopLogicSelect == SSDL_MODE_TWO_DIR);
	wire isLevelStart = (startStopLogicSelect == SSDL_MODE_LEVEL_START);
	wire isEdgeStart = (startStopLogicSelect == SSDL_MODE_EDGE_START);
	wire isEdgeMode = isTwoDir | isEdgeStart;
	wire modeChanged = (mode_r != startStopLogicSelect);
	wire firstCtl = syncIn.firstControlInput;
	wire secondCtl = syncIn.secondControlInput;
	wire runEn = syncIn.runEnableSource;
	wire kpStop = syncIn.keypadStop & keypadStopEnable;
	wire kpStartEdge = riseIn.keypadStart;
	wire firstCtlRise = riseIn.firstControlInput;
	wire secondCtlRise = riseIn.secondControlInput;
	wire forceStop = ~runEn | kpStop | modeChanged;
	wire startDir = secondCtl ? SSDL_DIR_REV : SSDL_DIR_FWD;

	// Mode register spots a change of control selection
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_r <= SSDL_MODE_TWO_DIR;
		end else begin
			mode_r <= startStopLogicSelect;
		end
	end

	// Command state; in edge modes LOCK waits for the start contact to open
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SSDL_IDLE: begin
				if (forceStop) begin
					state_nxt = isEdgeMode ? SSDL_LOCK : SSDL_IDLE;
				end else if (isTwoDir) begin
					if (firstCtlRise) begin
						state_nxt = SSDL_FWD;
					end else if (secondCtlRise) begin
						state_nxt = SSDL_REV;
					end
				end else if (isLevelStart) begin
					// Level start restarts as soon as enable returns
					if (firstCtl) begin
						state_nxt = secondCtl ? SSDL_REV : SSDL_FWD;
					end
				end else if (isEdgeStart) begin
					if (firstCtlRise) begin
						state_nxt = startDir ? SSDL_REV : SSDL_FWD;
					end
				end
			end
			SSDL_FWD: begin
				if (forceStop) begin
					state_nxt = isEdgeMode ? SSDL_LOCK : SSDL_IDLE;
				end else if (isTwoDir) begin
					// Backward edge while forward held is ignored
					if (!firstCtl) begin
						state_nxt = secondCtl ? SSDL_REV : SSDL_IDLE;
					end
				end else if (!firstCtl) begin
					state_nxt = SSDL_IDLE;
				end else if (secondCtl) begin
					state_nxt = SSDL_REV;
				end
			end
			SSDL_REV: begin
				if (forceStop) begin
					state_nxt = isEdgeMode ? SSDL_LOCK : SSDL_IDLE;
				end else if (isTwoDir) begin
					if (!secondCtl) begin
						state_nxt = firstCtl ? SSDL_FWD : SSDL_IDLE;
					end
				end else if (!firstCtl) begin
					state_nxt = SSDL_IDLE;
				end else if (!secondCtl) begin
					state_nxt = SSDL_FWD;
				end
			end
			SSDL_LOCK: begin
				// In edge modes released only once all start contacts are open; level mode leaves at once
				if (!isEdgeMode) begin
					state_nxt = SSDL_IDLE;
				end else if (!firstCtl && !(isTwoDir && secondCtl) && !forceStop) begin
					state_nxt = SSDL_IDLE;
				end
			end
			default: begin
				state_nxt = SSDL_IDLE;
			end
		endcase
		// Keypad start in level mode leaves the drive stopped while the first input is open
		if (isLevelStart && state_r == SSDL_IDLE && !forceStop && kpStartEdge && !firstCtl) begin
			state_nxt = SSDL_IDLE;
		end
	end

	// Output decode from next state
	always_comb begin
		cmd_nxt.run = (state_nxt == SSDL_FWD) || (state_nxt == SSDL_REV);
		cmd_nxt.reverse = (state_nxt == SSDL_REV) ? SSDL_DIR_REV : (state_nxt == SSDL_FWD ? SSDL_DIR_FWD : cmd_r.reverse);
		cmd_nxt.zeroFreq = !cmd_nxt.run;
	end

	// Reset leaves the drive stopped and, in edge modes, locked against a held contact
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= SSDL_LOCK;
			cmd_r <= '{run: SSDL_RST_RUN, reverse: SSDL_RST_DIR, zeroFreq: SSDL_RST_ZERO};
		end else begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
		end
	end

	assign cmdOut = cmd_r;

endmodule : ssdl_start_stop

//--- ssdl_pkg.sv
/*
 Package of the start/stop and direction logic: mode codes, reset values,
 the carrier structs for the command inputs and the command outputs.
 Assumes one clock domain and a synchronous active-high reset.
*/
package ssdl_pkg;

	localparam logic [2:0] SSDL_MODE_TWO_DIR = 3'h2;
	localparam logic [2:0] SSDL_MODE_LEVEL_START = 3'h3;
	localparam logic [2:0] SSDL_MODE_EDGE_START = 3'h4;
	localparam logic SSDL_DIR_FWD = 1'h0;
	localparam logic SSDL_DIR_REV = 1'h1;
	localparam logic SSDL_RST_RUN = 1'h0;
	localparam logic SSDL_RST_DIR = 1'h0;
	localparam logic SSDL_RST_ZERO = 1'h1;
	localparam int SSDL_SYNC_STAGES = 2;

	// Raw digital inputs from pins and keypad
	typedef struct packed {
		logic firstControlInput;
		logic secondControlInput;
		logic runEnableSource;
		logic keypadStart;
		logic keypadStop;
	} ssdl_in_t;

	// Commands to the ramp generator
	typedef struct packed {
		logic run;
		logic reverse;
		logic zeroFreq;
	} ssdl_cmd_t;

endpackage : ssdl_pkg

//--- ssdl_sync.sv
/*
 Two-flop synchroniser for a bus of pin-level inputs.
 Assumes the inputs are asynchronous to ref_clk; outputs feed both the edge detector and the start/stop logic downstream.
*/
`timescale 1ns/1ns
module ssdl_sync
	import ssdl_pkg::*;
#(
	parameter int WIDTH = 5
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
		end
	end

	assign syncOut = sync_r;

endmodule : ssdl_sync

//--- ssdl_edge.sv
/*
 Rising and falling edge detector for synchronised level signals.
 Assumes inputs already sit in the ref_clk domain.
*/
`timescale 1ns/1ns
module ssdl_edge
	import ssdl_pkg::*;
#(
	parameter int WIDTH = 5
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] prev_r;

	// Reset low like the synchroniser so no false edge follows reset;
	// a contact held through reset still shows a rise, the lock state absorbs it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prev_r <= '0;
		end else begin
			prev_r <= level;
		end
	end

	assign rise = level & ~prev_r;
	assign fall = ~level & prev_r;

endmodule : ssdl_edge

//--- ssdl_properties.sv
/* Checker bound to ssdl_start_stop: commands against delayed pin levels.
 Assumes pins reach cmdOut three edges after they are sampled. */
`timescale 1ns/1ns
module ssdl_properties
	import ssdl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [2:0] startStopLogicSelect,
	input wire logic keypadStopEnable,
	input wire ssdl_in_t pinIn,
	input wire ssdl_cmd_t cmdOut
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	ssdl_in_t p1_r, p2_r, p3_r, p4_r;
	logic [2:0] mode_r;
	// Named views of the mode and the pin history
	wire logic steady = startStopLogicSelect == mode_r;
	wire logic two = startStopLogicSelect == SSDL_MODE_TWO_DIR;
	wire logic go3 = p3_r.firstControlInput;
	wire logic go4 = p4_r.firstControlInput;
	wire logic rev3 = p3_r.secondControlInput;
	// Depth three matches two sync flops plus the output register
	always_ff @(posedge ref_clk) begin
		p1_r <= pinIn;
		p2_r <= p1_r;
		p3_r <= p2_r;
		p4_r <= p3_r;
		mode_r <= startStopLogicSelect;
	end
	a_reset_stopped: assert property ($fell(reset) |-> cmdOut == {SSDL_RST_RUN, SSDL_RST_DIR, SSDL_RST_ZERO})
		else $error("not stopped after reset");
	a_enable_stops: assert property (!p3_r.runEnableSource |-> !cmdOut.run && cmdOut.zeroFreq)
		else $error("ran while disabled");
	a_keypad_stops: assert property ($past(keypadStopEnable) && p3_r.keypadStop |-> !cmdOut.run && cmdOut.zeroFreq)
		else $error("keypad stop missed");
	a_start_needed: assert property (steady && !two && !go3 |-> !cmdOut.run)
		else $error("ran without start");
	a_dir_follows: assert property (steady && !two && cmdOut.run |-> cmdOut.reverse == rev3)
		else $error("direction wrong");
	a_start_edge: assert property (steady && startStopLogicSelect != SSDL_MODE_LEVEL_START && $rose(cmdOut.run)
		|-> go3 && !go4 || two && rev3 && !p4_r.secondControlInput)
		else $error("start without edge");
	a_rev_handover: assert property (two && steady && cmdOut.run && !go3 && rev3 |-> cmdOut.reverse)
		else $error("no reversal");
	a_first_wins: assert property (two && steady && $past(cmdOut.run) && !$past(cmdOut.reverse) && go3 |-> !cmdOut.reverse)
		else $error("second direction won");
endmodule : ssdl_properties

//--- ssdl_panel.sv
/* Operator panel model: contacts, run enable and keypad keys.
 Assumes the bench sets wanted levels; reopening a contact is its job. */
`timescale 1ns/1ns
module ssdl_panel
	import ssdl_pkg::*;
(
	input wire logic ref_clk,
	input wire ssdl_in_t want,
	output ssdl_in_t pinIn
);
	// Contacts move just after the edge, never on it
	initial pinIn = '0;
	always @(posedge ref_clk) pinIn <= #1 want;
endmodule : ssdl_panel

//--- tb_ssdl_start_stop.sv
/* Bench of ssdl_start_stop: corner steps in modes 2, 3 and 4 and one in unused mode 0, then random reversing.
 Assumes the panel model moves the pins and the checker is bound below. */
`timescale 1ns/1ns
module tb_ssdl_start_stop
	import ssdl_pkg::*;
;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic [2:0] startStopLogicSelect = SSDL_MODE_TWO_DIR;
	logic keypadStopEnable = 1'h1;
	ssdl_in_t want = 5'h14;
	ssdl_in_t pinIn;
	ssdl_cmd_t cmdOut;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] seed = 32'hA0AD;
	// Step: mode, {stop key on, 0, run, reverse}, pins {first, second, enable, start key, stop key}
	logic [15:0] steps [44] = '{16'h2814, 16'h2804, 16'h2A14, 16'h2A1C, 16'h2B0C, 16'h2804, 16'h2B0C, 16'h2804,
		16'h2A14, 16'h2810, 16'h2814, 16'h2804, 16'h2A14, 16'h2815, 16'h2814, 16'h2804, 16'h2A14, 16'h2215,
		16'h3804, 16'h3A14, 16'h3B1C, 16'h3A14, 16'h3804, 16'h380C, 16'h3A14, 16'h3810, 16'h3A14, 16'h3806,
		16'h4804, 16'h4A14, 16'h4B1C, 16'h4A14, 16'h4804, 16'h480C, 16'h4810, 16'h4814, 16'h4804, 16'h4A14,
		16'h4815, 16'h4814, 16'h4804, 16'h4A14, 16'h3804, 16'h0814};
	ssdl_start_stop i_ssdl_start_stop (.ref_clk, .reset, .startStopLogicSelect, .keypadStopEnable, .pinIn, .cmdOut);
	ssdl_panel i_ssdl_panel (.ref_clk, .want, .pinIn);
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	// Hang guard; the whole run needs under 600 cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			miscompares++;
			conclude();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs
	function automatic ssdl_cmd_t expectCmd(input logic [15:0] s);
		return {s[9], s[8], ~s[9]};
	endfunction : expectCmd
	task automatic chk(input ssdl_cmd_t seen, input ssdl_cmd_t exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD cmdOut expected %h seen %h", exp, seen);
		end
	endtask : chk
	// Apply one step, wait out the latency, compare; direction is open while stopped
	task automatic step(input logic [15:0] s);
		ssdl_cmd_t e;
		ssdl_cmd_t c;
		startStopLogicSelect = s[14:12];
		keypadStopEnable = s[11];
		want = s[4:0];
		repeat (7) @(posedge ref_clk);
		#1;
		e = expectCmd(s);
		c = cmdOut;
		if (!e.run) begin
			c.reverse = e.reverse;
		end
		chk(c, e);
	endtask : step
	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (20) @(posedge ref_clk);
		#1;
		reset = 1'h0;
		foreach (steps[i]) begin
			step(steps[i]);
		end
		// Level mode running; reverse and start key drawn at random
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			step({4'h3, 3'h5, seed[0], 3'h0, 1'h1, seed[0], 1'h1, seed[1], 1'h0});
		end
		conclude();
	end
endmodule : tb_ssdl_start_stop
bind ssdl_start_stop ssdl_properties i_ssdl_properties (.ref_clk, .reset, .startStopLogicSelect, .keypadStopEnable,
	.pinIn, .cmdOut);
